// *** common/vbc_pkg.sv ***
package vbc_pkg;

  // ************************************************************
  // sub-addresses and bus address
  // ************************************************************
  localparam logic [7:0] SUB_CHAN_ONE = 8'h01;
  localparam logic [7:0] SUB_CHAN_TWO = 8'h02;
  localparam logic [7:0] SUB_CHAN_THREE = 8'h03;
  localparam logic [7:0] SUB_SYNC = 8'h04;
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h0B;
  localparam int NUM_CHAN = 3;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CH_CLAMP_BIT = 7;
  localparam int CH_MUX_HI = 6;
  localparam int CH_MUX_LO = 3;
  localparam int CH_MODE_HI = 2;
  localparam int SY_MONITOR_BIT = 6;
  localparam int SY_BUFFER_BIT = 5;
  localparam int SY_VMUX_HI = 4;
  localparam int SY_VMUX_LO = 3;
  localparam int SY_HMUX_HI = 2;
  localparam int SY_HMUX_LO = 1;
  localparam int SY_ENABLE_BIT = 0;

  // ************************************************************
  // codes and reset values
  // ************************************************************
  localparam logic [3:0] MUX_LAST_A = 4'h4;
  localparam logic [3:0] MUX_LAST_B = 4'h9;
  localparam logic [1:0] SYNC_MUX_B = 2'h1;
  localparam logic [2:0] MODE_DISABLE = 3'h0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CHAN_PRESET_HI = 8'h04;
  localparam logic [7:0] SYNC_PRESET_HI = 8'h40;
  localparam logic [7:0] READ_RESERVED = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int STRAP_SETTLE_NS = 100;
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_DATA, ST_DATA_ACK,
    ST_IGNORE, ST_READ, ST_MASTER_ACK, ST_WAIT
  } vbc_state_t;

  typedef struct packed {
    logic clamp_fast;
    logic input_b;
    logic [2:0] mode;
    logic monitor_en;
    logic buffer_en;
  } vbc_chan_ctrl_t;

  typedef struct packed {
    logic vsync_input_b;
    logic hsync_input_b;
    logic sync_en;
  } vbc_sync_ctrl_t;

endpackage

// *** logic/vbc_i2c_ctrl.sv ***
`timescale 1ns/1ps
module vbc_i2c_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_high,
  input wire logic address_select_low,
  input wire logic power_up_config_strap,
  output vbc_pkg::vbc_chan_ctrl_t chan_ctrl [vbc_pkg::NUM_CHAN],
  output vbc_pkg::vbc_sync_ctrl_t sync_ctrl
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // order: scl, sda, address high, address low, strap
  logic [4:0] pins_meta_reg;
  logic [4:0] pins_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_reg <= 5'h03;
      pins_sync_reg <= 5'h03;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      pins_meta_reg <= {power_up_config_strap, address_select_low, address_select_high, sda_in, scl_in};
      pins_sync_reg <= pins_meta_reg;
      scl_prev_reg <= pins_sync_reg[0];
      sda_prev_reg <= pins_sync_reg[1];
    end
  end

  wire scl_s = pins_sync_reg[0];
  wire sda_s = pins_sync_reg[1];
  wire addr_hi_s = pins_sync_reg[2];
  wire addr_lo_s = pins_sync_reg[3];
  wire strap_s = pins_sync_reg[4];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire start_det = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
  wire stop_det = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

  // ************************************************************
  // bus state machine
  // ************************************************************
  vbc_pkg::vbc_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] sub_reg, sub_next;
  logic rw_reg, rw_next;
  logic sda_oe_reg, sda_oe_next;
  logic sda_out_reg;
  logic write_stb;

  // fixed pattern on top five bits
  wire addr_fixed_ok = shift_reg[7:3] == vbc_pkg::DEV_ADDR_FIXED;
  wire addr_match = addr_fixed_ok && shift_reg[2] == addr_hi_s && shift_reg[1] == addr_lo_s;
  wire byte_done = bit_cnt_reg == vbc_pkg::BITS_PER_BYTE;

  wire sel_ch0 = sub_reg == vbc_pkg::SUB_CHAN_ONE;
  wire sel_ch1 = sub_reg == vbc_pkg::SUB_CHAN_TWO;
  wire sel_ch2 = sub_reg == vbc_pkg::SUB_CHAN_THREE;
  wire sel_sync = sub_reg == vbc_pkg::SUB_SYNC;

  logic [7:0] chan_cfg_reg [vbc_pkg::NUM_CHAN];
  logic [7:0] sync_cfg_reg;

  wire [7:0] rd_byte = sel_ch0 ? chan_cfg_reg[0] :
                       sel_ch1 ? chan_cfg_reg[1] :
                       sel_ch2 ? chan_cfg_reg[2] :
                       sel_sync ? sync_cfg_reg : vbc_pkg::READ_RESERVED;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    sub_next = sub_reg;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    write_stb = 1'b0;
    if (start_det) begin
      // repeated start restarts address phase
      state_next = vbc_pkg::ST_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_det) begin
      state_next = vbc_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        vbc_pkg::ST_ADDR, vbc_pkg::ST_SUB, vbc_pkg::ST_DATA, vbc_pkg::ST_IGNORE: begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        vbc_pkg::ST_READ: begin
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        vbc_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              state_next = vbc_pkg::ST_ADDR_ACK;
              rw_next = shift_reg[0];
              sda_oe_next = 1'b1;
            end else begin
              state_next = vbc_pkg::ST_IDLE;
            end
          end
        end
        vbc_pkg::ST_ADDR_ACK: begin
          bit_cnt_next = 4'h0;
          if (rw_reg) begin
            // drive data bit after releasing ack
            state_next = vbc_pkg::ST_READ;
            sda_oe_next = !rd_byte[7];
            tx_next = {rd_byte[6:0], 1'b0};
          end else begin
            state_next = vbc_pkg::ST_SUB;
            sda_oe_next = 1'b0;
          end
        end
        vbc_pkg::ST_SUB: begin
          if (byte_done) begin
            // sub-address alone selects for a later read
            sub_next = shift_reg;
            state_next = vbc_pkg::ST_SUB_ACK;
            sda_oe_next = 1'b1;
          end
        end
        vbc_pkg::ST_SUB_ACK: begin
          state_next = vbc_pkg::ST_DATA;
          bit_cnt_next = 4'h0;
          sda_oe_next = 1'b0;
        end
        vbc_pkg::ST_DATA: begin
          if (byte_done) begin
            // ack held for one clock period
            write_stb = 1'b1;
            state_next = vbc_pkg::ST_DATA_ACK;
            sda_oe_next = 1'b1;
          end
        end
        vbc_pkg::ST_DATA_ACK: begin
          // further registers need a new transaction
          state_next = vbc_pkg::ST_IGNORE;
          bit_cnt_next = 4'h0;
          sda_oe_next = 1'b0;
        end
        vbc_pkg::ST_IGNORE: begin
          if (byte_done) begin
            bit_cnt_next = 4'h0;
          end
        end
        vbc_pkg::ST_READ: begin
          if (byte_done) begin
            // released for the master's ack slot
            state_next = vbc_pkg::ST_MASTER_ACK;
            sda_oe_next = 1'b0;
          end else begin
            sda_oe_next = !tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        vbc_pkg::ST_MASTER_ACK: begin
          // master ack or nack, either way the read ends
          state_next = vbc_pkg::ST_WAIT;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vbc_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sub_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sub_reg <= sub_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
      // open drain: only ever pulls low
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = sda_out_reg;

  // ************************************************************
  // configuration registers and strap preset
  // ************************************************************
  // strap sampled only after the synchroniser has settled
  logic [2:0] settle_cnt_reg;
  logic preset_done_reg;
  wire preset_load = !preset_done_reg && settle_cnt_reg == vbc_pkg::STRAP_SETTLE_CYC;
  // strap high gives buffers off, monitors on, ac-bias
  wire [7:0] chan_preset = strap_s ? vbc_pkg::CHAN_PRESET_HI : vbc_pkg::CFG_RESET;
  wire [7:0] sync_preset = strap_s ? vbc_pkg::SYNC_PRESET_HI : vbc_pkg::CFG_RESET;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_reg <= 3'h0;
      preset_done_reg <= 1'b0;
    end else if (!preset_done_reg) begin
      settle_cnt_reg <= settle_cnt_reg + 3'h1;
      preset_done_reg <= preset_load;
    end
  end

  // preset holds until a completed write replaces it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cfg_reg <= vbc_pkg::CFG_RESET;
    end else if (preset_load) begin
      sync_cfg_reg <= sync_preset;
    end else if (write_stb && sel_sync) begin
      sync_cfg_reg <= shift_reg;
    end
  end

  // ************************************************************
  // per-channel registers and control decode
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < vbc_pkg::NUM_CHAN; ch++) begin : g_chan
      wire sel_this = sub_reg == 8'(ch + 1);
      wire [3:0] mux_code = chan_cfg_reg[ch][vbc_pkg::CH_MUX_HI:vbc_pkg::CH_MUX_LO];
      wire [2:0] mode = chan_cfg_reg[ch][vbc_pkg::CH_MODE_HI:0];
      // mode 000 turns both paths off
      wire path_on = mode != vbc_pkg::MODE_DISABLE;
      vbc_pkg::vbc_chan_ctrl_t ctrl_next;
      assign ctrl_next.clamp_fast = chan_cfg_reg[ch][vbc_pkg::CH_CLAMP_BIT];
      // reserved mux codes fall back to input A
      assign ctrl_next.input_b = mux_code > vbc_pkg::MUX_LAST_A && mux_code <= vbc_pkg::MUX_LAST_B;
      assign ctrl_next.mode = mode;
      assign ctrl_next.monitor_en = path_on && sync_cfg_reg[vbc_pkg::SY_MONITOR_BIT];
      assign ctrl_next.buffer_en = path_on && sync_cfg_reg[vbc_pkg::SY_BUFFER_BIT];

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          chan_cfg_reg[ch] <= vbc_pkg::CFG_RESET;
          chan_ctrl[ch] <= '0;
        end else begin
          if (preset_load) begin
            chan_cfg_reg[ch] <= chan_preset;
          end else if (write_stb && sel_this) begin
            chan_cfg_reg[ch] <= shift_reg;
          end
          chan_ctrl[ch] <= ctrl_next;
        end
      end
    end
  endgenerate

  // sync mux selects, reserved codes give input A
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ctrl <= '0;
    end else begin
      sync_ctrl.vsync_input_b <= sync_cfg_reg[vbc_pkg::SY_VMUX_HI:vbc_pkg::SY_VMUX_LO] == vbc_pkg::SYNC_MUX_B;
      sync_ctrl.hsync_input_b <= sync_cfg_reg[vbc_pkg::SY_HMUX_HI:vbc_pkg::SY_HMUX_LO] == vbc_pkg::SYNC_MUX_B;
      sync_ctrl.sync_en <= sync_cfg_reg[vbc_pkg::SY_ENABLE_BIT];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  wire [31:0] cfg_word = {chan_cfg_reg[0], chan_cfg_reg[1], chan_cfg_reg[2], sync_cfg_reg};
  wire addr_end = state_reg == vbc_pkg::ST_ADDR && scl_fall && byte_done && !start_det && !stop_det;

  stop_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_det |=> state_reg == vbc_pkg::ST_IDLE && !sda_oe_reg) else $error("stop did not release bus");
  foreign_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && !addr_match |=> !sda_oe_reg && state_reg == vbc_pkg::ST_IDLE) else $error("acked foreign address");
  own_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    addr_end && addr_match |=> sda_oe_reg && state_reg == vbc_pkg::ST_ADDR_ACK) else $error("own address not acked");
  sub_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == vbc_pkg::ST_SUB_ACK |-> sda_oe_reg) else $error("sub-address ack missing");
  extra_nack_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == vbc_pkg::ST_IGNORE |-> !sda_oe_reg) else $error("extra byte acknowledged");
  single_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == vbc_pkg::ST_IGNORE && preset_done_reg |=> $stable(cfg_word)) else $error("second byte written");
  read_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == vbc_pkg::ST_ADDR_ACK && rw_reg && scl_fall && !start_det && !stop_det
      |=> sda_oe_reg == !$past(rd_byte[7])) else $error("read msb wrong");
  preset_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    preset_load && !strap_s |=> cfg_word == 32'h0000_0000) else $error("strap low preset wrong");
  preset_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    preset_load && strap_s |=> chan_cfg_reg[1] == vbc_pkg::CHAN_PRESET_HI && sync_cfg_reg == vbc_pkg::SYNC_PRESET_HI)
    else $error("strap high preset wrong");
  monitor_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_cfg_reg[vbc_pkg::SY_MONITOR_BIT] |=> !chan_ctrl[0].monitor_en && !chan_ctrl[2].monitor_en)
    else $error("monitor not forced off");
  buffer_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_cfg_reg[vbc_pkg::SY_BUFFER_BIT] |=> !chan_ctrl[0].buffer_en && !chan_ctrl[1].buffer_en)
    else $error("buffer not forced off");

endmodule

// *** verification/vbc_master_model.sv ***
`timescale 1ns/1ps
module vbc_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m,
  output logic res_valid,
  output logic [8:0] res_val
);
  // idle bus: both lines released high, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    res_valid = 1'b0;
    res_val = 9'h000;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ************************************************************
  // framing
  // ************************************************************
  // start and stop
  task automatic start();
    wait_clk(2);
    sda_m = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b0;
    wait_clk(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wait_clk(2);
    sda_m = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b1;
    wait_clk(4);
  endtask

  // ************************************************************
  // bits and bytes
  // ************************************************************
  // data moves mid-low so it never races the clock edge
  task automatic clock_bit(input logic b, output logic r);
    wait_clk(2);
    sda_m = b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    r = sda;
    scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, input logic ack_bit);
    logic [8:0] v;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], v[i]);
    end
    clock_bit(ack_bit, v[8]);
    res_val = v;
    res_valid = 1'b1;
    wait_clk(1);
    res_valid = 1'b0;
  endtask
endmodule

// *** verification/test_video_buffer_i2c_control.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %0t: %h not %h", $time, a, e); end end
module test_video_buffer_i2c_control;
  logic clk, rst_n, a_hi, a_lo, strap, sda_oe, sda_out, sda, scl, sda_m, res_valid;
  logic [8:0] res_val, note;
  logic [3:0] code;
  vbc_pkg::vbc_chan_ctrl_t chan [vbc_pkg::NUM_CHAN];
  vbc_pkg::vbc_sync_ctrl_t sync;
  logic [8:0] notes [$];
  logic [7:0] shadow [1:4];
  logic [7:0] sync_tab [5] = '{8'h00, 8'h6B, 8'h95, 8'hDE, 8'h61};
  int fails, comparisons, seed;

  // open drain: the device can only pull low
  assign sda = sda_oe ? sda_out : sda_m;

  vbc_i2c_ctrl dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_high(a_hi), .address_select_low(a_lo), .power_up_config_strap(strap),
    .chan_ctrl(chan), .sync_ctrl(sync));
  vbc_master_model master (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m), .res_valid(res_valid),
    .res_val(res_val));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] addr(input logic rw);
    return {vbc_pkg::DEV_ADDR_FIXED, a_hi, a_lo, rw};
  endfunction

  task automatic tx(input logic [7:0] d, input logic ab, input logic [8:0] exp);
    notes.push_back(exp);
    master.send(d, ab);
  endtask

  task automatic sub_only(input logic [7:0] sub);
    master.start();
    tx(addr(1'b0), 1'b1, {1'b0, addr(1'b0)});
    tx(sub, 1'b1, {1'b0, sub});
  endtask

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    sub_only(sub);
    tx(d, 1'b1, {1'b0, d});
    master.stop();
    if (sub >= vbc_pkg::SUB_CHAN_ONE && sub <= vbc_pkg::SUB_SYNC) shadow[sub[2:0]] = d;
  endtask

  task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
    sub_only(sub);
    master.stop();
    master.start();
    tx(addr(1'b1), 1'b1, {1'b0, addr(1'b1)});
    tx(8'hFF, 1'b1, {1'b1, exp});
    master.stop();
  endtask

  task automatic chk_ctrl();
    vbc_pkg::vbc_chan_ctrl_t e;
    vbc_pkg::vbc_sync_ctrl_t es;
    logic [7:0] c, s;
    repeat (4) @(negedge clk);
    s = shadow[4];
    for (int i = 0; i < vbc_pkg::NUM_CHAN; i++) begin
      c = shadow[i + 1];
      e.clamp_fast = c[7];
      e.input_b = c[6:3] > vbc_pkg::MUX_LAST_A && c[6:3] <= vbc_pkg::MUX_LAST_B;
      e.mode = c[2:0];
      e.monitor_en = c[2:0] != vbc_pkg::MODE_DISABLE && s[6];
      e.buffer_en = c[2:0] != vbc_pkg::MODE_DISABLE && s[5];
      `CHK(chan[i], e)
    end
    es.vsync_input_b = s[4:3] == vbc_pkg::SYNC_MUX_B;
    es.hsync_input_b = s[2:1] == vbc_pkg::SYNC_MUX_B;
    es.sync_en = s[0];
    `CHK(sync, es)
  endtask

  task automatic do_reset(input logic st);
    rst_n = 1'b0;
    strap = st;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    for (int i = 1; i <= 3; i++) shadow[i] = st ? vbc_pkg::CHAN_PRESET_HI : vbc_pkg::CFG_RESET;
    shadow[4] = st ? vbc_pkg::SYNC_PRESET_HI : vbc_pkg::CFG_RESET;
  endtask

  task automatic print_verdict();
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // oldest note against each byte the master saw
  always @(posedge clk) begin
    if (res_valid) begin
      note = notes.size() > 0 ? notes.pop_front() : 9'h1FF;
      `CHK(res_val, note)
    end
  end

  // about 10k cycles expected, generous margin
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {rst_n, a_hi, a_lo, strap, fails, comparisons, seed} = {4'b0010, 32'd0, 32'd0, 32'd55};
    do_reset(1'b0);
    chk_ctrl();
    rd(8'h01, 8'h00);
    do_reset(1'b1);
    chk_ctrl();
    sub_only(8'h02);
    master.stop();
    chk_ctrl();
    rd(8'h02, vbc_pkg::CHAN_PRESET_HI);
    for (int i = 1; i <= 3; i++) begin
      wr(8'(i), 8'($random(seed)));
      chk_ctrl();
      rd(8'(i), shadow[i]);
    end
    foreach (sync_tab[k]) begin
      wr(8'h04, sync_tab[k]);
      chk_ctrl();
    end
    for (int k = 0; k < 16; k++) begin
      code = 4'(k);
      wr(8'h01, {code[0], code, code[2:0]});
      chk_ctrl();
    end
    sub_only(8'h02);
    tx(8'h3A, 1'b1, {1'b0, 8'h3A});
    shadow[2] = 8'h3A;
    tx(8'hC5, 1'b1, {1'b1, 8'hC5});
    master.stop();
    chk_ctrl();
    wr(8'h05, 8'hA5);
    wr(8'h00, 8'h5A);
    chk_ctrl();
    rd(8'h05, vbc_pkg::READ_RESERVED);
    master.start();
    tx({vbc_pkg::DEV_ADDR_FIXED, ~a_hi, a_lo, 1'b0}, 1'b1, {1'b1, vbc_pkg::DEV_ADDR_FIXED, ~a_hi, a_lo, 1'b0});
    master.stop();
    master.start();
    tx({5'h0A, a_hi, a_lo, 1'b0}, 1'b1, {1'b1, 5'h0A, a_hi, a_lo, 1'b0});
    master.stop();
    a_hi = 1'b1;
    a_lo = 1'b0;
    wr(8'h03, 8'h26);
    chk_ctrl();
    sub_only(8'h03);
    master.stop();
    master.start();
    tx(addr(1'b1), 1'b1, {1'b0, addr(1'b1)});
    tx(8'hFF, 1'b0, {1'b0, 8'h26});
    tx(8'hFF, 1'b1, {1'b1, 8'hFF});
    master.stop();
    rd(8'h01, shadow[1]);
    print_verdict();
  end
endmodule
